// File: hw/adcsc_dev.sv
// Purpose: Control pin logic of the serial converter, device end.
// Assumes: All pins are asynchronous and pass two flip-flops first.
// Notes: The analog core is outside; it supplies a code and takes controls.
// Operation
// - Select fall clears counter; with sync high, enables input, output.
// - Input stops at sixteen edges or select rise.
// - Output released after select rises.
// - Host may use select as frame sync.
// - Start pin fall begins sampling.
// - Start pin rise holds and converts.
// - Start pin free of clock; low time samples.
// - End flag low from hold to done.
// - End flag used only in mode zero.
// - Interrupt falls at done; select or sync clears.
// - Interrupt fall releases the serial output.
// - Sync low at select fall waits input.
// - Sync fall clears counter, enables input.
// - Sync mode releases output after sixteenth bit.
// - Power pin low powers analog down.
// - Select or start pin wakes after power-up.
// - Serial clock shifts input and times conversion.
// - Most significant first; top nibble is command.
// - Config write carries twelve data bits.
// - Plain mode samples input on clock rise.
// - Sync mode samples input on clock fall.
// - Sync level at select fall picks mode.
// - Output result ten bits, then six zeros.
// - Plain mode changes output on clock fall.
`timescale 1ns/100ps
module adcsc_dev
    import adcsc_pkg::*;
#(
    parameter int SAMPLE_EDGES = SAMPLE_SHORT_EDGES,
    parameter int CONVERT_EDGES = CONV_EDGES
) (
    input wire logic clk, // System clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    adcsc_if.dev pins, // Serial and control pins.
    input wire logic [RESULT_W-1:0] analogCode, // Code from the analog core.
    output logic [2:0] channel, // Selected analog channel.
    output logic sampling, // Sample-and-hold is tracking.
    output logic analogPowerDown // Analog and reference circuits off.
);

    // ==========================================================
    // Parameter checks
    if (SAMPLE_EDGES < 1 || SAMPLE_EDGES > 31 || CONVERT_EDGES < 1 || CONVERT_EDGES > 31) begin
        $error("Edge counts must lie between 1 and 31.");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic [PIN_N-1:0] s3;
        adcsc_phase_t phase;
        logic fsMode;
        logic sdiEn;
        logic sdoOn;
        logic sdoBit;
        logic [CNT_W-1:0] inCnt;
        logic [FRAME_BITS-1:0] inSr;
        logic [FRAME_BITS-1:0] outSr;
        logic [CFG_W-1:0] cfg;
        logic readCfg;
        logic [2:0] chan;
        logic extSample;
        logic [CNT_W-1:0] edgeCnt;
        logic [RESULT_W-1:0] heldCode;
        logic [RESULT_W-1:0] result;
        logic eocIntN;
    } adcsc_dev_state_t;

    localparam adcsc_dev_state_t DEV_RST = '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE,
        phase: ADCSC_IDLE, cfg: CFG_RESET, result: RESULT_RESET, eocIntN: 1'b1, default: '0};

    adcsc_dev_state_t q;
    adcsc_dev_state_t d;

    // ==========================================================
    // Edge detection on the second and third stages only
    logic csLvl, fsLvl, sdiLvl;
    logic csFall, csRise, fsFall, fsRise, sclkRise, sclkFall, cstFall, cstRise;
    logic sampleEdge, shiftEdge, intMode, eocMode, powerLow;
    logic [CMD_W-1:0] cmdNow;
    logic [FRAME_BITS-1:0] wordNow;
    logic [FRAME_BITS-1:0] frameWord;

    assign csLvl = q.s2[PIN_CS];
    assign fsLvl = q.s2[PIN_FS];
    assign sdiLvl = q.s2[PIN_SDI];
    assign csFall = q.s3[PIN_CS] & ~q.s2[PIN_CS];
    assign csRise = ~q.s3[PIN_CS] & q.s2[PIN_CS];
    assign fsFall = q.s3[PIN_FS] & ~q.s2[PIN_FS];
    assign fsRise = ~q.s3[PIN_FS] & q.s2[PIN_FS];
    assign sclkRise = ~q.s3[PIN_SCLK] & q.s2[PIN_SCLK];
    assign sclkFall = q.s3[PIN_SCLK] & ~q.s2[PIN_SCLK];
    assign cstFall = q.s3[PIN_CST] & ~q.s2[PIN_CST];
    assign cstRise = ~q.s3[PIN_CST] & q.s2[PIN_CST];
    assign powerLow = ~q.s2[PIN_PWD];

    // Input is taken on rise in plain mode, on fall in sync mode.
    assign sampleEdge = q.fsMode ? sclkFall : sclkRise;
    // Output moves on the opposite edge.
    assign shiftEdge = q.fsMode ? sclkRise : sclkFall;

    // Word and command as they stand once the current bit is shifted in.
    assign wordNow = {q.inSr[FRAME_BITS-2:0], sdiLvl};
    assign cmdNow = wordNow[CMD_W-1:0];

    // Result first and six zero bits, or the configuration after a read command.
    assign frameWord = q.readCfg ? {{CMD_W{1'b0}}, q.cfg} :
        {q.result, {(FRAME_BITS - RESULT_W){1'b0}}};

    assign intMode = q.cfg[CFG_INT_BIT];
    assign eocMode = ~intMode & (q.cfg[CFG_MODE_LSB+1:CFG_MODE_LSB] == 2'b00);

    // ==========================================================
    // Next-state logic
    always_comb begin
        d = q;
        d.s1 = {pins.powerDownPinN, pins.conversionStartPinN, pins.frameSyncInputN,
            pins.sdi, pins.sclk, pins.chipSelectN};
        d.s2 = q.s1;
        d.s3 = q.s2;

        // Frame control.
        if (csRise) begin
            d.sdiEn = 1'b0;
            d.sdoOn = 1'b0;
        end else if (csFall) begin
            d.fsMode = ~fsLvl;
            d.inCnt = '0;
            d.sdiEn = fsLvl;
            d.sdoOn = fsLvl;
            d.outSr = frameWord;
            d.sdoBit = frameWord[FRAME_BITS-1];
            d.readCfg = 1'b0;
        end else if (!csLvl && fsFall) begin
            d.inCnt = '0;
            d.sdiEn = 1'b1;
            d.sdoOn = 1'b1;
            d.outSr = frameWord;
            d.sdoBit = frameWord[FRAME_BITS-1];
            d.readCfg = 1'b0;
        end else begin
            // Shift input on the sampling edge of the serial clock.
            if (q.sdiEn && sampleEdge) begin
                d.inSr = wordNow;
                d.inCnt = q.inCnt + 1'b1;
                if (q.inCnt == CNT_W'(FRAME_BITS - 1)) begin
                    d.sdiEn = 1'b0;
                    if (q.fsMode) begin
                        d.sdoOn = 1'b0;
                    end
                    if (wordNow[FRAME_BITS-1 -: CMD_W] == CMD_CFG_WRITE) begin
                        d.cfg = wordNow[CFG_W-1:0];
                    end
                    if (wordNow[FRAME_BITS-1 -: CMD_W] == CMD_CFG_READ) begin
                        d.readCfg = 1'b1;
                    end
                end
            end
            // Present the next output bit on the shifting edge.
            if (q.sdoOn && shiftEdge) begin
                d.outSr = {q.outSr[FRAME_BITS-2:0], 1'b0};
                d.sdoBit = q.outSr[FRAME_BITS-2];
            end
        end

        // Interrupt clear on a new select fall or a sync rise.
        if (intMode && (csFall || fsRise)) begin
            d.eocIntN = 1'b1;
        end

        // Conversion sequencing timed by the serial clock.
        case (q.phase)
            ADCSC_IDLE: begin
                if (q.sdiEn && sampleEdge && q.inCnt == CNT_W'(CMD_W - 1)
                        && cmdNow < CMD_W'(CMD_CHAN_LIMIT)) begin
                    d.phase = ADCSC_SAMPLE;
                    d.chan = cmdNow[2:0];
                    d.extSample = 1'b0;
                    d.edgeCnt = '0;
                end
            end
            ADCSC_SAMPLE: begin
                if ((q.extSample && cstRise) || (!q.extSample && sclkRise
                        && q.edgeCnt == CNT_W'(SAMPLE_EDGES - 1))) begin
                    d.phase = ADCSC_CONVERT;
                    d.heldCode = analogCode;
                    d.edgeCnt = '0;
                    if (eocMode) begin
                        d.eocIntN = 1'b0;
                    end
                end else if (!q.extSample && sclkRise) begin
                    d.edgeCnt = q.edgeCnt + 1'b1;
                end
            end
            ADCSC_CONVERT: begin
                if (sclkRise && q.edgeCnt == CNT_W'(CONVERT_EDGES - 1)) begin
                    d.phase = ADCSC_IDLE;
                    d.result = q.heldCode;
                    if (intMode) begin
                        d.eocIntN = 1'b0;
                        d.sdoOn = 1'b0;
                    end else begin
                        d.eocIntN = 1'b1;
                    end
                end else if (sclkRise) begin
                    d.edgeCnt = q.edgeCnt + 1'b1;
                end
            end
            ADCSC_SLEEP: begin
                if (!powerLow && csFall) begin
                    d.phase = ADCSC_IDLE;
                end
            end
            default: begin
                d.phase = ADCSC_IDLE;
            end
        endcase

        // Start pin fall opens extended sampling unless the power pin is low, select level aside.
        if (cstFall && !powerLow) begin
            d.phase = ADCSC_SAMPLE;
            d.extSample = 1'b1;
            d.edgeCnt = '0;
        end

        // Power pin low aborts any conversion and holds the core off.
        if (powerLow) begin
            d.phase = ADCSC_SLEEP;
            if (eocMode) begin
                d.eocIntN = 1'b1;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign pins.sdo = q.sdoBit;
    assign pins.sdoOeN = ~q.sdoOn;
    assign pins.eocIntN = q.eocIntN;
    assign channel = q.chan;
    assign sampling = (q.phase == ADCSC_SAMPLE);
    assign analogPowerDown = (q.phase == ADCSC_SLEEP);

endmodule

// File: pkg/adcsc_pkg.sv
// Purpose: Shared constants and types for the converter serial control pins.
// Assumes: One system clock at 100 MHz on both ends.
// Notes: Pin sample vectors use the PIN_* bit positions below.
package adcsc_pkg;

    // ==========================================================
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_W = 4;
    localparam int RESULT_W = 10;
    localparam int CFG_W = 12;
    localparam int CNT_W = 5;

    // ==========================================================
    // Positions of the sampled pins inside the synchroniser vector
    localparam int PIN_CS = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_FS = 3;
    localparam int PIN_CST = 4;
    localparam int PIN_PWD = 5;
    localparam int PIN_N = 6;
    // Idle pin levels: selects, frame sync, start and power pins high.
    localparam logic [5:0] PIN_IDLE = 6'h39;

    // ==========================================================
    // Commands and configuration fields
    localparam logic [3:0] CMD_CFG_READ = 4'h9;
    localparam logic [3:0] CMD_CFG_WRITE = 4'ha;
    localparam int CMD_CHAN_LIMIT = 8;
    localparam int CFG_INT_BIT = 2;
    localparam int CFG_MODE_LSB = 5;
    localparam logic [11:0] CFG_RESET = 12'h000;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // ==========================================================
    // Timing
    localparam int SAMPLE_SHORT_EDGES = 12;
    localparam int CONV_EDGES = 11;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_PERIOD_NS = 160;
    localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // ==========================================================
    // Converter phases and host frame phases
    typedef enum logic [1:0] {ADCSC_IDLE, ADCSC_SAMPLE, ADCSC_CONVERT, ADCSC_SLEEP} adcsc_phase_t;
    typedef enum logic [2:0] {HST_IDLE, HST_START, HST_FSUP, HST_FSDN, HST_XFER, HST_END}
        adcsc_hphase_t;

endpackage

// File: pkg/adcsc_if.sv
// Purpose: Pin bundle between the converter control end and the host end.
// Assumes: Both ends run on one shared 100 MHz clock.
// Notes: The serial output wire is resolved here from its enable.
`timescale 1ns/100ps
interface adcsc_if;
    logic chipSelectN;
    logic sclk;
    logic sdi;
    logic frameSyncInputN;
    logic conversionStartPinN;
    logic powerDownPinN;
    logic sdo;
    logic sdoOeN;
    logic eocIntN;
    logic sdoWire;

    // A released line shows the inverse of the last bit, so a late sample shows as an error.
    assign sdoWire = sdoOeN ? ~sdo : sdo;

    modport dev (
        input chipSelectN, sclk, sdi, frameSyncInputN, conversionStartPinN, powerDownPinN,
        output sdo, sdoOeN, eocIntN
    );
    modport host (
        output chipSelectN, sclk, sdi, frameSyncInputN, conversionStartPinN, powerDownPinN,
        input sdoWire, eocIntN
    );
endinterface

// File: hw/adcsc_host.sv
// Purpose: Host serial port end that drives the converter control pins.
// Assumes: The serial clock is made here by a divider and runs freely.
// Notes: One 16-bit frame per start request, with or without frame sync.
`timescale 1ns/100ps
module adcsc_host
    import adcsc_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_CYCLES
) (
    input wire logic clk, // System clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    adcsc_if.host pins, // Serial and control pins.
    input wire logic start, // Request one frame, one-cycle pulse.
    input wire logic useFrameSync, // Frame with frame sync when high.
    input wire logic [FRAME_BITS-1:0] txWord, // Word to send, first bit on top.
    input wire logic convStartReq, // Hold high to hold the start pin low.
    input wire logic powerDownReq, // Hold high to hold the power pin low.
    output logic busy, // A frame is in progress.
    output logic [FRAME_BITS-1:0] rxWord, // Word received in the last frame.
    output logic rxValid, // Received word valid, one-cycle pulse.
    output logic eocIntLow // Synchronised end or interrupt pin, high while the pin is low.
);

    // ==========================================================
    // Parameter checks
    // The returned bit needs five cycles through both synchronisers before it is sampled.
    if (SCLK_HALF < 6 || SCLK_HALF > 255) begin
        $error("Serial clock half period must lie between 6 and 255 cycles.");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] divCnt;
        logic sclk;
        adcsc_hphase_t phase;
        logic fsMode;
        logic [CNT_W-1:0] bitCnt;
        logic [FRAME_BITS-1:0] txSr;
        logic [FRAME_BITS-1:0] rxSr;
        logic [FRAME_BITS-1:0] rxWord;
        logic rxValid;
        logic csN;
        logic fsN;
        logic sdi;
        logic cstN;
        logic power_down_pin;
        logic [1:0] sdoSync;
        logic [1:0] eocSync;
    } adcsc_host_state_t;

    localparam adcsc_host_state_t HOST_RST = '{phase: HST_IDLE, csN: 1'b1, fsN: 1'b1,
        cstN: 1'b1, power_down_pin: 1'b1, eocSync: 2'b11, default: '0};

    adcsc_host_state_t q;
    adcsc_host_state_t d;

    logic tick, sclkRise, sclkFall, hostSample, hostChange;

    // Divider tick toggles the serial clock every half period.
    assign tick = (q.divCnt == 8'(SCLK_HALF - 1));
    assign sclkRise = tick & ~q.sclk;
    assign sclkFall = tick & q.sclk;
    assign hostSample = q.fsMode ? sclkFall : sclkRise;
    assign hostChange = q.fsMode ? sclkRise : sclkFall;

    // ==========================================================
    // Next-state logic
    always_comb begin
        d = q;
        d.rxValid = 1'b0;
        d.divCnt = tick ? 8'h00 : q.divCnt + 8'h01;
        d.sclk = q.sclk ^ tick;
        d.sdoSync = {q.sdoSync[0], pins.sdoWire};
        d.eocSync = {q.eocSync[0], pins.eocIntN};
        d.cstN = ~convStartReq;
        d.power_down_pin = ~powerDownReq;

        case (q.phase)
            HST_IDLE: begin
                if (start) begin
                    d.txSr = txWord;
                    d.fsMode = useFrameSync;
                    d.phase = HST_START;
                end
            end
            HST_START: begin
                // Select falls while the clock is low.
                if (sclkFall) begin
                    d.csN = 1'b0;
                    d.bitCnt = '0;
                    if (q.fsMode) begin
                        d.fsN = 1'b0;
                        d.phase = HST_FSUP;
                    end else begin
                        d.sdi = q.txSr[FRAME_BITS-1];
                        d.phase = HST_XFER;
                    end
                end
            end
            HST_FSUP: begin
                if (sclkRise) begin
                    d.fsN = 1'b1;
                    d.phase = HST_FSDN;
                end
            end
            HST_FSDN: begin
                if (sclkRise) begin
                    d.fsN = 1'b0;
                    d.sdi = q.txSr[FRAME_BITS-1];
                    d.phase = HST_XFER;
                end
            end
            HST_XFER: begin
                if (hostSample) begin
                    d.rxSr = {q.rxSr[FRAME_BITS-2:0], q.sdoSync[1]};
                    d.bitCnt = q.bitCnt + 1'b1;
                    if (q.bitCnt == CNT_W'(FRAME_BITS - 1)) begin
                        d.phase = HST_END;
                    end
                end
                if (hostChange) begin
                    d.txSr = {q.txSr[FRAME_BITS-2:0], 1'b0};
                    d.sdi = q.txSr[FRAME_BITS-2];
                    d.fsN = 1'b1;
                end
            end
            HST_END: begin
                if (hostChange) begin
                    d.csN = 1'b1;
                    d.fsN = 1'b1;
                    d.sdi = 1'b0;
                    d.rxWord = q.rxSr;
                    d.rxValid = 1'b1;
                    d.phase = HST_IDLE;
                end
            end
            default: begin
                d.phase = HST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= HOST_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign pins.chipSelectN = q.csN;
    assign pins.sclk = q.sclk;
    assign pins.sdi = q.sdi;
    assign pins.frameSyncInputN = q.fsN;
    assign pins.conversionStartPinN = q.cstN;
    assign pins.powerDownPinN = q.power_down_pin;
    assign busy = (q.phase != HST_IDLE);
    assign rxWord = q.rxWord;
    assign rxValid = q.rxValid;
    assign eocIntLow = ~q.eocSync[1];

endmodule

// File: tb/adcsc_props.sv
// Purpose: Timing checks on the pins between converter end and host end.
// Assumes: Pins change just after clk edges; device answers three cycles later.
// Notes: Pin relations are checked; the interrupt clear check holds only with the interrupt selected.
`timescale 1ns/100ps
module adcsc_props (
    input wire logic clk, // System clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic chipSelectN, // Select pin.
    input wire logic frameSyncInputN, // Frame sync pin.
    input wire logic powerDownPinN, // Power pin.
    input wire logic sdoOeN, // Output enable, low while driving.
    input wire logic eocIntN // End or interrupt pin.
);
    // Longest drive time of one frame in cycles, with margin.
    localparam int DRIVE_MAX = 270;
    int drvCnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // Helper counter
    // Counts cycles for which the serial output is driven without a break.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drvCnt <= 0;
        end else if (sdoOeN) begin
            drvCnt <= 0;
        end else begin
            drvCnt <= drvCnt + 1;
        end
    end

    // ==========================================================
    // Assertions
    a_sel_drive: assert property ($fell(chipSelectN) && frameSyncInputN && powerDownPinN
        |-> ##[1:4] !sdoOeN) else $error("output not driven after select fall");
    a_sel_release: assert property ($rose(chipSelectN) |-> ##[1:4] sdoOeN)
        else $error("output not released after select rise");
    a_idle_hiz: assert property (chipSelectN [*5] |-> sdoOeN)
        else $error("output driven while not selected");
    a_sync_wait: assert property ($fell(chipSelectN) && !frameSyncInputN
        |-> sdoOeN [*8]) else $error("output driven before frame sync fall");
    a_sync_drive: assert property (!$past(chipSelectN) && !chipSelectN
        && $fell(frameSyncInputN) |-> ##[1:4] !sdoOeN) else $error("no drive after sync fall");
    a_sleep_hiz: assert property (!powerDownPinN [*6] |-> sdoOeN)
        else $error("output driven while powered down");
    a_int_clear: assert property ($fell(chipSelectN) && !eocIntN
        |-> ##[1:4] eocIntN) else $error("interrupt not cleared by select fall");
    a_drive_bound: assert property (drvCnt <= DRIVE_MAX)
        else $error("output driven past end of frame");
endmodule

// File: tb/adcsc_bench.sv
// Purpose: Self-checking bench joining the converter end and the host end.
// Assumes: Host inputs and analog code change on the falling clock edge.
// Notes: Results are worked out from the codes handed to the analog input.
`timescale 1ns/100ps
module adcsc_bench;
    import adcsc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic useFrameSync = 1'b0;
    logic [FRAME_BITS-1:0] txWord = 16'h0000;
    logic convStartReq = 1'b0;
    logic powerDownReq = 1'b0;
    logic [RESULT_W-1:0] analogCode = 10'h000;
    logic busy, rxValid, eocIntLow, sampling, analogPowerDown;
    logic [FRAME_BITS-1:0] rxWord, rx;
    logic [2:0] channel;
    int error_cnt = 0;
    int total_checks = 0;

    adcsc_if bus ();
    adcsc_dev adcsc_dev_i (.clk(clk), .arst_n(arst_n), .pins(bus), .analogCode(analogCode),
        .channel(channel), .sampling(sampling), .analogPowerDown(analogPowerDown));
    adcsc_host adcsc_host_i (.clk(clk), .arst_n(arst_n), .pins(bus), .start(start),
        .useFrameSync(useFrameSync), .txWord(txWord), .convStartReq(convStartReq),
        .powerDownReq(powerDownReq), .busy(busy), .rxWord(rxWord), .rxValid(rxValid),
        .eocIntLow(eocIntLow));
    adcsc_props adcsc_props_i (.clk(clk), .arst_n(arst_n), .chipSelectN(bus.chipSelectN),
        .frameSyncInputN(bus.frameSyncInputN), .powerDownPinN(bus.powerDownPinN),
        .sdoOeN(bus.sdoOeN), .eocIntN(bus.eocIntN));

    // The clock inverts every half period of 5 ns.
    always #5 clk = ~clk;

    // ==========================================================
    // Tasks
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Runs one host frame and returns the word received.
    task automatic frame(input logic fs, input logic [15:0] word, output logic [15:0] got);
        int n;
        @(negedge clk);
        useFrameSync = fs;
        txWord = word;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        check({15'h0, busy}, 16'h0001);
        for (n = 0; n < 2000 && rxValid !== 1'b1; n++) @(negedge clk);
        if (n == 2000) begin
            error_cnt++;
            test_done();
        end
        got = rxWord;
        @(negedge clk);
    endtask

    // Waits a bounded time for the end or interrupt level.
    task automatic waitEoc(input logic level);
        int n;
        for (n = 0; n < 1000 && eocIntLow !== level; n++) @(negedge clk);
        if (n == 1000) begin
            error_cnt++;
            test_done();
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        // Plain frame with a channel command; nothing converted yet.
        analogCode = 10'h2a5;
        frame(1'b0, 16'h3000, rx);
        check(rx, {RESULT_RESET, 6'h00});
        check({13'h0, channel}, 16'h0003);
        waitEoc(1'b1);
        waitEoc(1'b0);
        // Frame sync frame returns the last result.
        analogCode = 10'h15a;
        frame(1'b1, 16'h0000, rx);
        check(rx, {10'h2a5, 6'h00});
        waitEoc(1'b1);
        waitEoc(1'b0);
        // Configuration write selects the interrupt, then read it back.
        frame(1'b0, 16'ha004, rx);
        check(rx, {10'h15a, 6'h00});
        frame(1'b0, 16'h9000, rx);
        check(rx, {10'h15a, 6'h00});
        analogCode = 10'h0f0;
        frame(1'b0, 16'h0000, rx);
        check(rx, 16'h0004);
        waitEoc(1'b1);
        // A sync frame with an unused command clears the interrupt.
        frame(1'b1, 16'hf000, rx);
        check(rx, {10'h0f0, 6'h00});
        check({15'h0, eocIntLow}, 16'h0000);
        // Start pin controls the sampling time while not selected.
        analogCode = 10'h3c3;
        convStartReq = 1'b1;
        repeat (40) @(negedge clk);
        check({15'h0, sampling}, 16'h0001);
        convStartReq = 1'b0;
        repeat (8) @(negedge clk);
        check({15'h0, sampling}, 16'h0000);
        waitEoc(1'b1);
        frame(1'b0, 16'hf000, rx);
        check(rx, {10'h3c3, 6'h00});
        // Power pin puts the analog part to sleep until a select wakes it.
        powerDownReq = 1'b1;
        repeat (10) @(negedge clk);
        check({15'h0, analogPowerDown}, 16'h0001);
        powerDownReq = 1'b0;
        repeat (10) @(negedge clk);
        check({15'h0, analogPowerDown}, 16'h0001);
        frame(1'b0, 16'hf000, rx);
        check({15'h0, analogPowerDown}, 16'h0000);
        // A conversion mode other than zero keeps the end flag quiet.
        analogCode = 10'h1e1;
        frame(1'b0, 16'ha020, rx);
        check(rx, {10'h3c3, 6'h00});
        frame(1'b0, 16'h1000, rx);
        check({15'h0, eocIntLow}, 16'h0000);
        check({13'h0, channel}, 16'h0001);
        repeat (200) @(negedge clk);
        check({15'h0, eocIntLow}, 16'h0000);
        frame(1'b0, 16'hf000, rx);
        check(rx, {10'h1e1, 6'h00});
        test_done();
    end
endmodule
